// ===== verilog/srl_pkg_stage.sv
// lane remap package and the per-direction latency stage
`timescale 1ns/1ps
`default_nettype none

package srl_pkg;
  localparam int unsigned LANES = 8;
  localparam int unsigned LANE_W = 32;
  localparam int unsigned IDX_W = 3;

  typedef enum logic [1:0] {
    SRL_MAP_LIN = 2'b00,
    SRL_MAP_P28 = 2'b01,
    SRL_MAP_DD = 2'b10
  } srl_map_t;

  localparam srl_map_t MAP_RST = SRL_MAP_LIN;

  // cycles a map must hold before the checks trust the pipeline contents
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // entry p holds the lane index that drives pin position p
  localparam logic [LANES-1:0][IDX_W-1:0] TBL_LIN =
    {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [LANES-1:0][IDX_W-1:0] TBL_P28 =
    {3'h7, 3'h5, 3'h6, 3'h4, 3'h3, 3'h1, 3'h2, 3'h0};
  localparam logic [LANES-1:0][IDX_W-1:0] TBL_DD =
    {3'h3, 3'h1, 3'h7, 3'h5, 3'h6, 3'h4, 3'h2, 3'h0};

  // extra register stages on top of the common output flop
  localparam logic [1:0] EXTRA_LIN = 2'h0;
  localparam logic [1:0] EXTRA_P28 = 2'h1;
  localparam logic [1:0] EXTRA_DD = 2'h2;

  typedef struct packed {
    logic vld;
    logic [LANES-1:0][LANE_W-1:0] dat;
  } srl_stream_t;

  localparam srl_stream_t STREAM_RST = '0;
endpackage

// one direction: zero, one or two extra stages, then the output flop
module srl_lat_stage (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] extra_i,
  input wire srl_pkg::srl_stream_t d_i,
  output srl_pkg::srl_stream_t q_o
);
  srl_pkg::srl_stream_t s1_q;
  srl_pkg::srl_stream_t s2_q;
  srl_pkg::srl_stream_t out_d;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= srl_pkg::STREAM_RST;
      s2_q <= srl_pkg::STREAM_RST;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  always_comb begin
    unique case (extra_i)
      srl_pkg::EXTRA_P28: out_d = s1_q; // [R4]
      srl_pkg::EXTRA_DD: out_d = s2_q; // [R5]
      default: out_d = d_i; // [R6]
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_o <= srl_pkg::STREAM_RST;
    end else begin
      q_o <= out_d;
    end
  end
endmodule

`default_nettype wire

// ===== verilog/srl_lane_remap.sv
// lane permutation between pcs lanes and serdes pin positions for one quad pair
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: one map setting drives all eight lanes, so both quads of the pair always share the map.
// R2: the pluggable-28 map swaps lanes 1 and 2 of each quad and keeps lanes 0 and 3 in place.
// R3: the double-density map orders the eight lanes of both quads as 0,2,4,6,5,7,1,3.
// R4: the pluggable-28 map adds exactly one register stage to every lane path.
// R5: the double-density map adds exactly two register stages to every lane path.
// R6: the linear map passes each lane to its own position with no added stage.
// R7: the map is a static three-value setting, linear after reset, shared by transmit and receive.
module srl_lane_remap (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_we_i,
  input wire srl_pkg::srl_map_t cfg_map_i,
  input wire srl_pkg::srl_stream_t tx_pcs_i,
  input wire srl_pkg::srl_stream_t rx_pin_i,
  output srl_pkg::srl_stream_t tx_pin_o,
  output srl_pkg::srl_stream_t rx_pcs_o,
  output srl_pkg::srl_map_t map_o
);
  typedef logic [srl_pkg::LANES-1:0][srl_pkg::LANE_W-1:0] srl_lanes_t;
  typedef logic [srl_pkg::LANES-1:0][srl_pkg::IDX_W-1:0] srl_tbl_t;

  srl_pkg::srl_map_t map_q;
  logic [1:0] extra;
  srl_tbl_t tbl;
  srl_pkg::srl_stream_t tx_map;
  srl_pkg::srl_stream_t rx_map;

  function automatic srl_tbl_t tbl_of(input srl_pkg::srl_map_t m);
    unique case (m)
      srl_pkg::SRL_MAP_P28: tbl_of = srl_pkg::TBL_P28;
      srl_pkg::SRL_MAP_DD: tbl_of = srl_pkg::TBL_DD;
      default: tbl_of = srl_pkg::TBL_LIN;
    endcase
  endfunction

  function automatic srl_lanes_t fwd(input srl_lanes_t d, input srl_tbl_t t);
    srl_lanes_t r;
    r = '0;
    for (int p = 0; p < srl_pkg::LANES; p++) begin
      r[p] = d[t[p]];
    end
    return r;
  endfunction

  function automatic srl_lanes_t rev(input srl_lanes_t d, input srl_tbl_t t);
    srl_lanes_t r;
    r = '0;
    for (int p = 0; p < srl_pkg::LANES; p++) begin
      r[t[p]] = d[p];
    end
    return r;
  endfunction

  // static setting; an undefined code on the config port is ignored
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      map_q <= srl_pkg::MAP_RST; // [R7]
    end else if (cfg_we_i && (cfg_map_i == srl_pkg::SRL_MAP_LIN ||
                              cfg_map_i == srl_pkg::SRL_MAP_P28 ||
                              cfg_map_i == srl_pkg::SRL_MAP_DD)) begin
      map_q <= cfg_map_i; // [R7]
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      map_o <= srl_pkg::MAP_RST;
    end else begin
      map_o <= map_q;
    end
  end

  // one table for all eight lanes keeps both quads on the same map
  always_comb begin
    tbl = tbl_of(map_q); // [R1] [R2] [R3]
    unique case (map_q)
      srl_pkg::SRL_MAP_P28: extra = srl_pkg::EXTRA_P28; // [R4]
      srl_pkg::SRL_MAP_DD: extra = srl_pkg::EXTRA_DD; // [R5]
      default: extra = srl_pkg::EXTRA_LIN; // [R6]
    endcase
  end

  always_comb begin
    tx_map.vld = tx_pcs_i.vld;
    tx_map.dat = fwd(tx_pcs_i.dat, tbl); // [R7]
    rx_map.vld = rx_pin_i.vld;
    rx_map.dat = rev(rx_pin_i.dat, tbl); // [R7]
  end

  srl_lat_stage u_tx (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .extra_i(extra),
    .d_i(tx_map),
    .q_o(tx_pin_o)
  );

  srl_lat_stage u_rx (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .extra_i(extra),
    .d_i(rx_map),
    .q_o(rx_pcs_o)
  );

  // cycles since the map last changed, saturating; checks wait for a settled map
  logic [1:0] age_q;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_q <= 2'h0;
    end else if (map_q != map_o) begin
      age_q <= 2'h0;
    end else if (age_q != srl_pkg::SETTLE_CYC) begin
      age_q <= age_q + 2'h1;
    end
  end

  logic settled;
  assign settled = (age_q == srl_pkg::SETTLE_CYC) && (map_q == map_o);

  a_lin_passthru: assert property ( // [R6]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_LIN) |=>
      (tx_pin_o == $past(tx_pcs_i)) && (rx_pcs_o == $past(rx_pin_i)))
    else $error("linear map is not a one-cycle pass-through");

  a_p28_latency: assert property ( // [R4]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_P28) ##1 (map_q == srl_pkg::SRL_MAP_P28) |=>
      tx_pin_o.vld == $past(tx_pcs_i.vld, 2))
    else $error("pluggable-28 valid not delayed by two cycles");

  a_dd_latency: assert property ( // [R5]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_DD) ##1 (map_q == srl_pkg::SRL_MAP_DD)[*2] |=>
      tx_pin_o.vld == $past(tx_pcs_i.vld, 3))
    else $error("double-density valid not delayed by three cycles");

  a_p28_swap_lo: assert property ( // [R2]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_P28) ##1 (map_q == srl_pkg::SRL_MAP_P28) |=>
      tx_pin_o.dat[1] == $past(tx_pcs_i.dat[2], 2) &&
      tx_pin_o.dat[2] == $past(tx_pcs_i.dat[1], 2) &&
      tx_pin_o.dat[0] == $past(tx_pcs_i.dat[0], 2) &&
      tx_pin_o.dat[3] == $past(tx_pcs_i.dat[3], 2))
    else $error("pluggable-28 lower quad not swapped as expected");

  a_p28_both_quads: assert property ( // [R1]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_P28) ##1 (map_q == srl_pkg::SRL_MAP_P28) |=>
      tx_pin_o.dat[5] == $past(tx_pcs_i.dat[6], 2) &&
      tx_pin_o.dat[6] == $past(tx_pcs_i.dat[5], 2) &&
      tx_pin_o.dat[4] == $past(tx_pcs_i.dat[4], 2) &&
      tx_pin_o.dat[7] == $past(tx_pcs_i.dat[7], 2))
    else $error("upper quad not on the same map as lower quad");

  a_dd_order: assert property ( // [R3]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_DD) ##1 (map_q == srl_pkg::SRL_MAP_DD)[*2] |=>
      tx_pin_o.dat[1] == $past(tx_pcs_i.dat[2], 3) &&
      tx_pin_o.dat[2] == $past(tx_pcs_i.dat[4], 3) &&
      tx_pin_o.dat[3] == $past(tx_pcs_i.dat[6], 3) &&
      tx_pin_o.dat[4] == $past(tx_pcs_i.dat[5], 3) &&
      tx_pin_o.dat[5] == $past(tx_pcs_i.dat[7], 3) &&
      tx_pin_o.dat[6] == $past(tx_pcs_i.dat[1], 3) &&
      tx_pin_o.dat[7] == $past(tx_pcs_i.dat[3], 3))
    else $error("double-density lane order wrong");

  a_rx_inverse: assert property ( // [R7]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_DD) ##1 (map_q == srl_pkg::SRL_MAP_DD)[*2] |=>
      rx_pcs_o.dat[2] == $past(rx_pin_i.dat[1], 3) &&
      rx_pcs_o.dat[1] == $past(rx_pin_i.dat[6], 3) &&
      rx_pcs_o.dat[3] == $past(rx_pin_i.dat[7], 3))
    else $error("receive direction not the inverse of transmit map");

  a_map_static: assert property ( // [R7]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !cfg_we_i |=> $stable(map_q))
    else $error("map changed without a configuration write");

  a_map_legal: assert property ( // [R7]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    map_o != 2'b11)
    else $error("map holds an undefined code");

  a_p28_rx_swap: assert property ( // [R2]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (settled && map_q == srl_pkg::SRL_MAP_P28) ##1 (map_q == srl_pkg::SRL_MAP_P28) |=>
      rx_pcs_o.dat[1] == $past(rx_pin_i.dat[2], 2) &&
      rx_pcs_o.dat[2] == $past(rx_pin_i.dat[1], 2) &&
      rx_pcs_o.dat[5] == $past(rx_pin_i.dat[6], 2) &&
      rx_pcs_o.dat[6] == $past(rx_pin_i.dat[5], 2))
    else $error("pluggable-28 receive lanes not swapped back");

  a_bad_code_kept: assert property ( // [R7]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (cfg_we_i && cfg_map_i == srl_pkg::srl_map_t'(2'b11)) |=> $stable(map_q))
    else $error("undefined map code was not ignored");

  a_map_out_follows: assert property ( // [R7]
    @(posedge core_clk_i) disable iff (!arst_n_i)
    map_o == $past(map_q))
    else $error("map output does not follow the map register");

  c_lin_traffic: cover property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    settled && map_q == srl_pkg::SRL_MAP_LIN && tx_pcs_i.vld ##1 tx_pin_o.vld);

  c_p28_traffic: cover property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    settled && map_q == srl_pkg::SRL_MAP_P28 && tx_pcs_i.vld ##2 tx_pin_o.vld);

  c_dd_traffic: cover property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    settled && map_q == srl_pkg::SRL_MAP_DD && rx_pin_i.vld ##3 rx_pcs_o.vld);

  c_map_switch: cover property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    map_q == srl_pkg::SRL_MAP_LIN ##1 map_q == srl_pkg::SRL_MAP_DD);
endmodule

`default_nettype wire

// ===== bench/srl_serdes_model.sv
// serdes side model: pin positions looped back to the receive pins one cycle later
`timescale 1ns/1ps
`default_nettype none
module srl_serdes_model (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire srl_pkg::srl_stream_t tx_pin_i,
  output var srl_pkg::srl_stream_t rx_pin_o
);
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_pin_o <= '0;
    end else begin
      rx_pin_o <= tx_pin_i;
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_serdes_lane_remap.sv
// self-checking bench: random lane traffic under every map, pins looped back
`timescale 1ns/1ps
`default_nettype none
module test_serdes_lane_remap;
  typedef struct {srl_pkg::srl_stream_t s; int due;} srl_note_t;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cfg_we_i = 1'b0;
  srl_pkg::srl_map_t cfg_map_i = srl_pkg::SRL_MAP_LIN;
  srl_pkg::srl_stream_t tx_pcs_i = '0;
  srl_pkg::srl_stream_t rx_pin_i;
  srl_pkg::srl_stream_t tx_pin_o;
  srl_pkg::srl_stream_t rx_pcs_o;
  srl_pkg::srl_map_t map_o;
  srl_pkg::srl_map_t cur = srl_pkg::SRL_MAP_LIN;
  srl_pkg::srl_map_t modes[6] = '{srl_pkg::SRL_MAP_P28, srl_pkg::SRL_MAP_DD,
    srl_pkg::srl_map_t'(2'b11), srl_pkg::SRL_MAP_LIN, srl_pkg::SRL_MAP_DD, srl_pkg::SRL_MAP_P28};
  srl_note_t txq[$];
  srl_note_t rxq[$];
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hD65F;

  srl_lane_remap dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cfg_we_i(cfg_we_i),
    .cfg_map_i(cfg_map_i), .tx_pcs_i(tx_pcs_i), .rx_pin_i(rx_pin_i), .tx_pin_o(tx_pin_o),
    .rx_pcs_o(rx_pcs_o), .map_o(map_o));
  srl_serdes_model far (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .tx_pin_i(tx_pin_o),
    .rx_pin_o(rx_pin_i));

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // pin position p carries lane t[p]
  function automatic srl_pkg::srl_stream_t perm(input srl_pkg::srl_map_t m,
                                                input srl_pkg::srl_stream_t s);
    int t[8];
    srl_pkg::srl_stream_t r;
    case (m)
      srl_pkg::SRL_MAP_P28: t = '{0, 2, 1, 3, 4, 6, 5, 7};
      srl_pkg::SRL_MAP_DD: t = '{0, 2, 4, 6, 5, 7, 1, 3};
      default: t = '{0, 1, 2, 3, 4, 5, 6, 7};
    endcase
    r = s;
    for (int p = 0; p < 8; p++) begin
      r.dat[p] = s.dat[t[p]];
    end
    return r;
  endfunction

  task automatic retire(input string name, ref srl_note_t q[$], input srl_pkg::srl_stream_t g);
    tests_run++;
    if (q.size() == 0) begin
      mismatches++;
      $display("[FAIL] %s expected none seen %h", name, g);
    end else begin
      if (g !== q[0].s || cyc != q[0].due) begin
        mismatches++;
        $display("[FAIL] %s expected %h at %0d seen %h at %0d", name, q[0].s, q[0].due, g, cyc);
      end
      void'(q.pop_front());
    end
  endtask

  task automatic cmp_map(input srl_pkg::srl_map_t e);
    tests_run++;
    if (map_o !== e) begin
      mismatches++;
      $display("[FAIL] map_o expected %h seen %h", e, map_o);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one sample per edge; transmit notes carry the permuted value, receive notes the unpermuted one, each with the edge it is due
  task automatic drive(input int n, input bit live);
    srl_pkg::srl_stream_t s;
    int l;
    repeat (n) begin
      @(posedge core_clk_i);
      for (int i = 0; i < 8; i++) begin
        seed = xs(seed);
        s.dat[i] = seed;
      end
      s.vld = live & seed[3];
      l = (cur == srl_pkg::SRL_MAP_DD) ? 3 : (cur == srl_pkg::SRL_MAP_P28) ? 2 : 1;
      if (s.vld) begin
        txq.push_back('{perm(cur, s), cyc + l + 1});
        rxq.push_back('{s, cyc + 2 * l + 2});
      end
      tx_pcs_i <= s;
    end
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (arst_n_i && tx_pin_o.vld === 1'b1) begin
      retire("tx_pin_o", txq, tx_pin_o);
    end
    if (arst_n_i && rx_pcs_o.vld === 1'b1) begin
      retire("rx_pcs_o", rxq, rx_pcs_o);
    end
  end

  initial begin
    repeat (19) @(posedge core_clk_i);
    #1 cmp_map(srl_pkg::SRL_MAP_LIN);
    @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    drive(30, 1'b1);
    foreach (modes[i]) begin
      drive(10, 1'b0);
      @(posedge core_clk_i);
      cfg_we_i <= 1'b1;
      cfg_map_i <= modes[i];
      @(posedge core_clk_i);
      cfg_we_i <= 1'b0;
      if (modes[i] != srl_pkg::srl_map_t'(2'b11)) cur = modes[i];
      drive(4, 1'b0);
      #1 cmp_map(cur);
      drive(30, 1'b1);
    end
    drive(12, 1'b0);
    tests_run++;
    if (txq.size() + rxq.size() != 0) begin
      mismatches++;
      $display("[FAIL] pending notes expected 0 seen %0d", txq.size() + rxq.size());
    end
    @(posedge core_clk_i);
    arst_n_i <= 1'b0;
    drive(2, 1'b0);
    #1 cmp_map(srl_pkg::SRL_MAP_LIN);
    give_verdict();
  end

  // about 350 edges are needed; ten times that means a hang
  initial begin
    #(3500 * 50);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
